// ===== spsc_bank.sv
/*
 Control and status register bank of the combined SPI and I2C port,
 reached over APB, with start/stop detection on the synchronised pins.
 Assumes a shift engine on pclk that reports bytes and sequence ends.
*/
module spsc_bank
	import spsc_pkg::*;
(
	input  wire logic        pclk,         // Module clock, 25 MHz
	input  wire logic        presetn,      // Async reset, active low
	input  wire logic        psel,         // APB select
	input  wire logic        penable,      // APB enable
	input  wire logic        pwrite,       // APB direction
	input  wire logic [15:0] paddr,        // APB byte address
	input  wire logic [31:0] pwdata,       // APB write data
	output logic      [31:0] prdata,       // APB read data
	output logic             pready,       // APB ready
	output logic             pslverr,      // APB error, unmapped
	input  wire logic        scl_pin,      // Serial clock pin level
	input  wire logic        sda_pin,      // Serial data pin level
	input  wire logic        rx_valid,     // Engine byte received
	input  wire logic [7:0]  rx_data,      // Engine received byte
	input  wire logic        tx_done,      // Engine byte sent
	input  wire logic        byte_is_addr, // Moved byte was an address
	input  wire logic        addr_match,   // Slave address matched
	input  wire logic        rw_bit,       // Direction bit at match
	input  wire logic        nack_seen,    // Not-acknowledge seen
	input  wire logic        master_tx,    // Master transmit busy
	input  wire logic        ua_set,       // Address rewrite needed
	input  wire logic [4:0]  seq_done,     // Sequence request ends
	output logic [7:0]       tx_byte,      // Byte to transmit
	output logic             tx_load,      // Transmit load pulse
	output logic [7:0]       mode,         // Control one copy
	output logic [7:0]       ctrl_three,   // Control three copy
	output logic [7:0]       reload_addr,  // Reload or address
	output logic [7:0]       addr_mask,    // Slave address mask
	output logic [4:0]       seq_request,  // Sequence request bits
	output logic             samp_end,     // Sample at end of bit
	output logic             slew_en,      // Slew control on
	output logic             tx_idle_edge, // Shift on active-to-idle
	output logic             smbus_levels, // SMBus input levels
	output logic             pins_gpio,    // Pins back to port use
	output logic             active,       // Port active
	output logic             irq           // Interrupt, level
);
	spsc_state_type st_reg;
	spsc_state_type st_next;
	logic           scl_s;
	logic           sda_s;
	logic           acc;
	logic           wr;
	logic           rd;
	logic [11:0]    idx;
	logic           is_i2c;
	logic           is_mst;
	logic           is_slv;
	logic           is_10b;
	logic           is_spi_mst;
	logic           start_ev;
	logic           stop_ev;
	logic [7:0]     rdv;
	logic           mapped;

	// Pins cross into pclk through the filter
	spsc_pin_sync #(.RST_LEVEL(1'b1)) u_scl (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (scl_pin),
		.level   (scl_s)
	);
	spsc_pin_sync #(.RST_LEVEL(1'b1)) u_sda (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (sda_pin),
		.level   (sda_s)
	);

	// Bus access decode; one wait state keeps pready a flop
	// Read side effects fall on the capture edge, so an event landing there survives
	assign acc = psel && penable && st_reg.pready;
	assign wr  = acc && pwrite && mapped;
	assign rd  = psel && penable && !st_reg.pready && !pwrite && mapped;
	assign idx = paddr[13:2];

	// Mode decode from port_mode_select
	assign is_mst     = (st_reg.con1[3:0] == MD_I2C_MST) || (st_reg.con1[3:0] == MD_I2C_FW);
	assign is_10b     = (st_reg.con1[3:0] == MD_SL10) || (st_reg.con1[3:0] == MD_SL10I);
	assign is_slv     = is_10b || (st_reg.con1[3:0] == MD_SL7) || (st_reg.con1[3:0] == MD_SL7I);
	assign is_i2c     = is_mst || is_slv;
	assign is_spi_mst = (st_reg.con1[3:0] <= 4'h3) || (st_reg.con1[3:0] == MD_SPI_MSA);

	// Bus conditions: sda moves while scl is high
	assign start_ev = scl_s && st_reg.sda_prev && !sda_s;
	assign stop_ev  = scl_s && !st_reg.sda_prev && sda_s;

	// Read mux
	always_comb begin
		rdv    = 8'h00;
		mapped = 1'b1;
		unique case (idx)
			IDX_BUF:  rdv = st_reg.shift_buffer;
			IDX_ADDR: rdv = st_reg.addr;
			IDX_MSK:  rdv = st_reg.msk;
			IDX_STAT: rdv = st_reg.stat;
			IDX_CON1: rdv = st_reg.con1;
			IDX_CON2: rdv = st_reg.con2;
			IDX_CON3: rdv = st_reg.con3;
			IDX_EVT:  rdv = st_reg.evt;
			IDX_EMSK: rdv = st_reg.emsk;
			default:  mapped = 1'b0;
		endcase
		if (paddr[15:14] != 2'b00 || paddr[1:0] != 2'b00) begin
			mapped = 1'b0;
		end
	end

	// Next state of the whole bank; all flags move on one edge
	always_comb begin
		st_next          = st_reg;
		st_next.pready   = psel && penable && !st_reg.pready;
		st_next.pslverr  = psel && penable && !st_reg.pready && !mapped;
		st_next.tx_load  = 1'b0;
		st_next.sda_prev = sda_s;
		if (psel && penable && !st_reg.pready && !pwrite) begin
			st_next.prdata = mapped ? rdv : 8'h00; // Unmapped reads give zero
		end

		// Software writes; status keeps its read-only bits
		if (wr) begin
			unique case (idx)
				IDX_ADDR: begin
					st_next.addr           = pwdata[7:0];
					st_next.stat[ST_UA]    = 1'b0;
				end
				IDX_MSK:  st_next.msk  = pwdata[7:0];
				IDX_STAT: st_next.stat[7:6] = pwdata[7:6];
				IDX_CON1: st_next.con1 = pwdata[7:0];
				IDX_CON2: st_next.con2 = pwdata[7:0];
				IDX_CON3: st_next.con3 = pwdata[7:0];
				IDX_EMSK: st_next.emsk = pwdata[7:0];
				IDX_BUF: begin
					// Write while the last byte is pending is a collision
					if (st_reg.stat[ST_BF]) begin
						st_next.con1[C1_WRITE_COLLISION_FLAG] = 1'b1;
						st_next.evt[EV_ERR]   = 1'b1;
					end else begin
						st_next.shift_buffer = pwdata[7:0];
						st_next.stat[ST_BF]  = 1'b1;
						st_next.tx_load      = 1'b1;
					end
				end
				default: ;
			endcase
		end

		// Reads with side effects
		if (rd && idx == IDX_BUF) begin
			st_next.stat[ST_BF] = 1'b0;
		end
		if (rd && idx == IDX_EVT) begin
			st_next.evt = 8'h00;
		end

		// Sequence requests end by the engine
		st_next.con2[4:0] = st_next.con2[4:0] & ~seq_done;

		// Transmitted byte leaves the buffer free
		if (tx_done) begin
			st_next.stat[ST_BF] = 1'b0;
			st_next.stat[ST_DA] = !byte_is_addr;
			st_next.evt[EV_TX]  = 1'b1;
		end

		// Received byte; ack and stop bits never reach here
		if (rx_valid) begin
			st_next.evt[EV_RX] = 1'b1;
			st_next.stat[ST_DA] = !byte_is_addr;
			if (st_reg.stat[ST_BF] && !(rd && idx == IDX_BUF)) begin
				st_next.con1[C1_OV] = 1'b1;
				st_next.evt[EV_ERR] = 1'b1;
			end else begin
				st_next.shift_buffer = rx_data;
				st_next.stat[ST_BF]  = 1'b1;
			end
		end

		// Direction bit by mode
		if (is_mst) begin
			st_next.stat[ST_RW] = master_tx;
		end else if (is_slv) begin
			if (addr_match) begin
				st_next.stat[ST_RW] = rw_bit;
			end else if (start_ev || stop_ev || nack_seen) begin
				st_next.stat[ST_RW] = 1'b0;
			end
		end

		// Update request only in 10-bit slave; set wins over the write
		if (ua_set && is_10b) begin
			st_next.stat[ST_UA] = 1'b1;
		end

		// Last bus condition seen
		if (is_i2c && start_ev) begin
			st_next.stat[ST_S]    = 1'b1;
			st_next.stat[ST_P]    = 1'b0;
			st_next.evt[EV_START] = 1'b1;
		end
		if (is_i2c && stop_ev) begin
			st_next.stat[ST_P]   = 1'b1;
			st_next.stat[ST_S]   = 1'b0;
			st_next.evt[EV_STOP] = 1'b1;
		end
		// Disabled port forgets bus conditions
		if (!st_reg.con1[C1_EN]) begin
			st_next.stat[ST_S] = 1'b0;
			st_next.stat[ST_P] = 1'b0;
		end

		// Mode-derived pin controls, registered so outputs come from flops
		st_next.samp_end     = is_spi_mst && st_reg.stat[ST_SMP];
		st_next.slew_en      = is_i2c && !st_reg.stat[ST_SMP];
		st_next.tx_idle_edge = !is_i2c && st_reg.stat[ST_CKE];
		st_next.smbus        = is_i2c && st_reg.stat[ST_CKE];
		st_next.gpio         = !st_reg.con1[C1_EN];
		st_next.active       = (is_mst && st_reg.stat[ST_RW]) | (|st_reg.con2[4:0]);
		st_next.irq          = |(st_next.evt & st_next.emsk);
	end

	// Single state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg          <= '0;
			st_reg.stat     <= RST_STAT;
			st_reg.con1     <= RST_CON1;
			st_reg.evt      <= RST_REG;
			st_reg.emsk     <= RST_REG;
			st_reg.sda_prev <= 1'b1;
			st_reg.gpio     <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state flops
	assign prdata       = {24'h000000, st_reg.prdata};
	assign pready       = st_reg.pready;
	assign pslverr      = st_reg.pslverr;
	assign tx_byte      = st_reg.shift_buffer;
	assign tx_load      = st_reg.tx_load;
	assign mode         = st_reg.con1;
	assign ctrl_three   = st_reg.con3;
	assign reload_addr  = st_reg.addr;
	assign addr_mask    = st_reg.msk;
	assign seq_request  = st_reg.con2[4:0];
	assign samp_end     = st_reg.samp_end;
	assign slew_en      = st_reg.slew_en;
	assign tx_idle_edge = st_reg.tx_idle_edge;
	assign smbus_levels = st_reg.smbus;
	assign pins_gpio    = st_reg.gpio;
	assign active       = st_reg.active;
	assign irq          = st_reg.irq;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_buf_write;
		wr && idx == IDX_BUF && !st_reg.stat[ST_BF];
	endsequence
	sequence s_buf_read;
		rd && idx == IDX_BUF && !rx_valid;
	endsequence

	property p_smp_master;
		(is_spi_mst && st_reg.stat[ST_SMP]) |=> samp_end;
	endproperty
	a_smp_master: assert property (p_smp_master) else $error("sample phase not applied");

	property p_slew;
		(is_i2c && !st_reg.stat[ST_SMP]) |=> slew_en;
	endproperty
	a_slew: assert property (p_slew) else $error("slew control not enabled");

	property p_smbus;
		(is_i2c && st_reg.stat[ST_CKE]) |=> smbus_levels && !tx_idle_edge;
	endproperty
	a_smbus: assert property (p_smbus) else $error("edge select misrouted");

	property p_da;
		(is_slv && rx_valid && !tx_done) |=> st_reg.stat[ST_DA] == !$past(byte_is_addr);
	endproperty
	a_da: assert property (p_da) else $error("data address bit wrong");

	property p_stop;
		(is_i2c && stop_ev && st_reg.con1[C1_EN]) |=> st_reg.stat[ST_P] && !st_reg.stat[ST_S];
	endproperty
	a_stop: assert property (p_stop) else $error("stop flag not set");

	property p_start;
		(is_i2c && start_ev && st_reg.con1[C1_EN]) |=> st_reg.stat[ST_S] && !st_reg.stat[ST_P];
	endproperty
	a_start: assert property (p_start) else $error("start flag not set");

	property p_dis_clear;
		!st_reg.con1[C1_EN] |=> !st_reg.stat[ST_S] && !st_reg.stat[ST_P];
	endproperty
	a_dis_clear: assert property (p_dis_clear) else $error("flags kept while disabled");

	property p_rw_slave;
		(is_slv && addr_match) |=> st_reg.stat[ST_RW] == $past(rw_bit);
	endproperty
	a_rw_slave: assert property (p_rw_slave) else $error("direction not captured");

	property p_rw_master;
		is_mst |=> st_reg.stat[ST_RW] == $past(master_tx);
	endproperty
	a_rw_master: assert property (p_rw_master) else $error("transmit bit wrong");

	property p_active;
		##1 active == $past((is_mst && st_reg.stat[ST_RW]) || (|st_reg.con2[4:0]));
	endproperty
	a_active: assert property (p_active) else $error("active indication wrong");

	property p_ua;
		(ua_set && is_10b) |=> st_reg.stat[ST_UA];
	endproperty
	a_ua: assert property (p_ua) else $error("update flag not set");

	property p_bf_tx;
		s_buf_write ##1 !tx_done[*1] |=> st_reg.stat[ST_BF];
	endproperty
	a_bf_tx: assert property (p_bf_tx) else $error("buffer full not held");

	property p_bf_rx;
		s_buf_read |=> !st_reg.stat[ST_BF];
	endproperty
	a_bf_rx: assert property (p_bf_rx) else $error("buffer full not cleared");

	property p_gpio;
		!st_reg.con1[C1_EN] |=> pins_gpio;
	endproperty
	a_gpio: assert property (p_gpio) else $error("pins not released");
endmodule

// ===== spsc_pkg.sv
/*
 Package of the serial port status and control bank: register indices,
 field positions, mode codes, reset values and shared state types.
 Assumes a 32-bit APB master and a byte-wide register view.
*/
// Functional notes
// - In SPI master mode a set sample phase bit samples input at the end of output time, clear at the middle.
// - In I2C mode a set sample phase bit disables slew control, a clear one enables it.
// - The edge select bit picks the SPI shift edge, and in I2C enables SMBus input levels.
// - In I2C slave mode the data/address bit shows whether the last byte moved was data.
// - In I2C mode the stop flag is set when a stop was the last bus condition seen.
// - In I2C mode the start flag is set when a start was the last bus condition seen.
// - Reset and a cleared port enable clear both the start and the stop flag.
// - In I2C slave mode the direction bit holds the address-match direction until start, stop or nack.
// - In I2C master mode the direction bit shows a transmit in progress.
// - The active indication is the OR of the transmit bit and the five sequence request bits; the code uses the transmit bit in I2C master mode only.
// - In 10-bit slave mode the update flag asks software to rewrite the address register.
// - During transmit the buffer full flag stays set until the written byte has gone out.
// - During receive the buffer full flag stays set until the received byte is read.
// - A cleared port enable turns the port off and hands the pins back to plain port use; the code still records start and stop events then.
package spsc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_BUF  = 12'hf91;
	localparam logic [11:0] IDX_ADDR = 12'hf92;
	localparam logic [11:0] IDX_MSK  = 12'hf93;
	localparam logic [11:0] IDX_STAT = 12'hf94;
	localparam logic [11:0] IDX_CON1 = 12'hf95;
	localparam logic [11:0] IDX_CON2 = 12'hf96;
	localparam logic [11:0] IDX_CON3 = 12'hf97;
	localparam logic [11:0] IDX_EVT  = 12'hf98;
	localparam logic [11:0] IDX_EMSK = 12'hf99;
	// Status bit positions
	localparam int ST_SMP = 7;
	localparam int ST_CKE = 6;
	localparam int ST_DA  = 5;
	localparam int ST_P   = 4;
	localparam int ST_S   = 3;
	localparam int ST_RW  = 2;
	localparam int ST_UA  = 1;
	localparam int ST_BF  = 0;
	// Control one bit positions
	localparam int C1_WRITE_COLLISION_FLAG = 7;
	localparam int C1_OV   = 6;
	localparam int C1_EN   = 5;
	localparam int C1_CKP  = 4;
	// Event bit positions
	localparam int EV_START = 0;
	localparam int EV_STOP  = 1;
	localparam int EV_RX    = 2;
	localparam int EV_TX    = 3;
	localparam int EV_ERR   = 4;
	// Reset values
	localparam logic [7:0] RST_STAT = 8'h00;
	localparam logic [7:0] RST_CON1 = 8'h00;
	localparam logic [7:0] RST_REG  = 8'h00;
	// Mode codes of port_mode_select
	localparam logic [3:0] MD_I2C_MST = 4'h8;
	localparam logic [3:0] MD_I2C_FW  = 4'hb;
	localparam logic [3:0] MD_SPI_MSA = 4'ha;
	localparam logic [3:0] MD_SPI_SLV = 4'h4;
	localparam logic [3:0] MD_SPI_SL2 = 4'h5;
	localparam logic [3:0] MD_SL7     = 4'h6;
	localparam logic [3:0] MD_SL10    = 4'h7;
	localparam logic [3:0] MD_SL7I    = 4'he;
	localparam logic [3:0] MD_SL10I   = 4'hf;
	// Whole state of the bank
	typedef struct packed {
		logic [7:0] shift_buffer;
		logic [7:0] addr;
		logic [7:0] msk;
		logic [7:0] stat;
		logic [7:0] con1;
		logic [7:0] con2;
		logic [7:0] con3;
		logic [7:0] evt;
		logic [7:0] emsk;
		logic [7:0] prdata;
		logic       pready;
		logic       pslverr;
		logic       irq;
		logic       active;
		logic       tx_load;
		logic       sda_prev;
		logic       samp_end;
		logic       slew_en;
		logic       tx_idle_edge;
		logic       smbus;
		logic       gpio;
	} spsc_state_type;
endpackage

// ===== spsc_pin_sync.sv
/*
 Three-flop pin synchroniser with agreement filter.
 Assumes an asynchronous pin level and an active-low asynchronous reset.
*/
module spsc_pin_sync #(
	parameter logic RST_LEVEL = 1'b1
) (
	input  wire logic pclk,    // Module clock
	input  wire logic presetn, // Async reset, active low
	input  wire logic pin,     // Raw pin level
	output logic      level    // Filtered level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} spsc_sync_type;
	spsc_sync_type sy_reg;
	spsc_sync_type sy_next;

	// First flop feeds only the second; level moves once two and three agree
	always_comb begin
		sy_next    = sy_reg;
		sy_next.s1 = pin;
		sy_next.s2 = sy_reg.s1;
		sy_next.s3 = sy_reg.s2;
		if (sy_reg.s2 == sy_reg.s3) begin
			sy_next.level = sy_reg.s3;
		end
	end

	// Reset to the idle level so no false edge follows reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sy_reg <= {4{RST_LEVEL}};
		end else begin
			sy_reg <= sy_next;
		end
	end

	assign level = sy_reg.level; // Straight from the filter flop
endmodule

// ===== spsc_i2c_model.sv
/*
 Bus-side partner of the serial port bank: makes start and stop
 conditions on the clock and data lines at the 320 ns link rate.
 Assumes pulled-up lines that rest high and a caller that waits.
*/
module spsc_i2c_model (
	output logic scl, // Serial clock line
	output logic sda  // Serial data line
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF_NS = 160; // Half of the link clock period
	localparam int SKEW_NS = 20;  // Keeps pin moves off the rising clock edge

	// Pull-ups hold both lines high; the clock stands still between frames
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	// Data falls while the clock is high, then the clock is held low
	task automatic start_cond();
		#SKEW_NS;
		sda = 1'b1;
		#HALF_NS;
		scl = 1'b1;
		#HALF_NS;
		sda = 1'b0;
		#HALF_NS;
		scl = 1'b0;
		#HALF_NS;
	endtask

	// Data rises while the clock is high; both lines then rest high
	task automatic stop_cond();
		#SKEW_NS;
		sda = 1'b0;
		#HALF_NS;
		scl = 1'b1;
		#HALF_NS;
		sda = 1'b1;
		#HALF_NS;
	endtask
endmodule

// ===== serial_port_status_control_tb.sv
/*
 Self-checking bench of the serial port status and control bank.
 Assumes APB answers with pready and a bus model drives the pins.
*/
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module serial_port_status_control_tb
	import spsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready, pslverr, scl_pin, sda_pin;
	logic [4:0]  stb = 5'h00, seq_done = 5'h00, seq_request;
	logic        byte_is_addr = 1'b0, rw_bit = 1'b0, master_tx = 1'b0;
	logic [7:0]  rx_data = 8'h00, tx_byte, rnd;
	logic        samp_end, slew_en, tx_idle_edge, smbus_levels, pins_gpio, active, irq;
	logic        tx_load;
	logic [7:0]  mode, ctrl_three, reload_addr, addr_mask;
	logic [32:0] note_q[$];
	logic [32:0] exp_note;
	int          n_errors = 0, samples_checked = 0, i, n_loads = 0;
	integer      seed = 32'ha15868ee;

	// 40 ns bench clock
	always #20 pclk = ~pclk;

	spsc_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_pin(scl_pin), .sda_pin(sda_pin), .rx_valid(stb[0]),
		.rx_data(rx_data), .tx_done(stb[1]), .byte_is_addr(byte_is_addr),
		.addr_match(stb[2]), .rw_bit(rw_bit), .nack_seen(stb[3]), .master_tx(master_tx),
		.ua_set(stb[4]), .seq_done(seq_done), .tx_byte(tx_byte), .tx_load(tx_load),
		.mode(mode), .ctrl_three(ctrl_three), .reload_addr(reload_addr),
		.addr_mask(addr_mask), .seq_request(seq_request),
		.samp_end(samp_end), .slew_en(slew_en), .tx_idle_edge(tx_idle_edge),
		.smbus_levels(smbus_levels), .pins_gpio(pins_gpio), .active(active), .irq(irq));

	spsc_i2c_model bus (.scl(scl_pin), .sda(sda_pin));

	task automatic print_verdict();
		$display("checks=%0d errors=%0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// One APB transfer; the expected answer is noted before the request goes out
	task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d,
		input logic [7:0] exp, input logic err);
		int n;
		note_q.push_back({err, 24'h000000, exp});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 16) begin
			n_errors++;
			print_verdict();
		end
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, 8'h00, 1'b0);
	endtask

	task automatic rd(input logic [11:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00, exp, 1'b0);
	endtask

	// Outputs lag their cause by a cycle; let them land
	task automatic settle();
		repeat (2) @(posedge pclk);
	endtask

	task automatic pulse(input int b);
		stb[b] <= 1'b1;
		@(posedge pclk);
		stb <= 5'h00;
		settle();
	endtask

	// Pin conditions pass a slow synchroniser, so wait well past it
	task automatic cond(input logic stop);
		if (stop)
			bus.stop_cond();
		else
			bus.start_cond();
		repeat (8) @(posedge pclk);
	endtask

	// Completed transfers are matched against the oldest note
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (note_q.size() == 0) begin
				n_errors++;
			end else begin
				exp_note = note_q.pop_front();
				`CHK((pwrite ? {pslverr, 32'h00000000} : {pslverr, prdata}), exp_note)
			end
		end
	end

	// Load pulses stand one cycle; count them where they stand
	always @(posedge pclk) begin
		if (tx_load === 1'b1)
			n_loads++;
	end

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(IDX_STAT, RST_STAT);
		rd(IDX_CON1, RST_CON1);
		apb(1'b0, 12'h000, 8'h00, 8'h00, 1'b1);
		`CHK(pins_gpio, 1'b1)
		wr(IDX_CON1, 8'h20 | {4'h0, MD_SPI_MSA});
		wr(IDX_STAT, 8'hff);
		settle();
		rd(IDX_STAT, 8'hc0);
		`CHK(samp_end, 1'b1)
		`CHK(tx_idle_edge, 1'b1)
		`CHK(pins_gpio, 1'b0)
		wr(IDX_STAT, 8'h40);
		settle();
		`CHK(samp_end, 1'b0)
		wr(IDX_CON1, 8'h20 | {4'h0, MD_I2C_MST});
		settle();
		`CHK(slew_en, 1'b1)
		`CHK(smbus_levels, 1'b1)
		wr(IDX_STAT, 8'h80);
		settle();
		`CHK(slew_en, 1'b0)
		`CHK(smbus_levels, 1'b0)
		wr(IDX_STAT, 8'h00);
		settle();
		`CHK(slew_en, 1'b1)
		master_tx <= 1'b1;
		settle();
		rd(IDX_STAT, 8'h04);
		`CHK(active, 1'b1)
		master_tx <= 1'b0;
		settle();
		rd(IDX_STAT, 8'h00);
		// Each sequence request alone must raise the active indication
		for (i = 0; i < 5; i++) begin
			wr(IDX_CON2, 8'h01 << i);
			settle();
			`CHK(seq_request, 5'h01 << i)
			`CHK(active, 1'b1)
			seq_done <= 5'h01 << i;
			@(posedge pclk);
			seq_done <= 5'h00;
			settle();
			`CHK(active, 1'b0)
		end
		wr(IDX_CON1, 8'h20 | {4'h0, MD_SPI_SLV});
		settle();
		`CHK(samp_end, 1'b0)
		`CHK(mode, 8'h24)
		// Slave mode keeps samp_end low whatever the sample phase bit
		wr(IDX_EMSK, 8'h03);
		wr(IDX_CON1, 8'h20 | {4'h0, MD_SL7});
		cond(1'b0);
		rd(IDX_STAT, 8'h08);
		`CHK(irq, 1'b1)
		rd(IDX_EVT, 8'h01);
		settle();
		`CHK(irq, 1'b0)
		cond(1'b1);
		rd(IDX_STAT, 8'h10);
		cond(1'b0);
		wr(IDX_CON1, {4'h0, MD_SL7});
		settle();
		rd(IDX_STAT, 8'h00);
		`CHK(pins_gpio, 1'b1)
		wr(IDX_CON1, 8'h20 | {4'h0, MD_SL7});
		rnd = 8'($random(seed));
		rx_data <= rnd;
		pulse(0);
		rd(IDX_STAT, 8'h21);
		rd(IDX_BUF, rnd);
		rd(IDX_STAT, 8'h20);
		rw_bit <= 1'b1;
		pulse(2);
		rd(IDX_STAT, 8'h24);
		pulse(3);
		rd(IDX_STAT, 8'h20);
		rnd = 8'($random(seed));
		wr(IDX_BUF, rnd);
		settle();
		`CHK(tx_byte, rnd)
		`CHK(n_loads, 1)
		wr(IDX_BUF, ~rnd);
		settle();
		`CHK(n_loads, 1)
		`CHK(tx_byte, rnd)
		`CHK(mode[C1_WRITE_COLLISION_FLAG], 1'b1)
		rd(IDX_STAT, 8'h21);
		pulse(1);
		rd(IDX_STAT, 8'h20);
		wr(IDX_CON1, 8'h20 | {4'h0, MD_SL10});
		pulse(4);
		rd(IDX_STAT, 8'h22);
		wr(IDX_ADDR, 8'h5a);
		rd(IDX_STAT, 8'h20);
		rd(IDX_ADDR, 8'h5a);
		`CHK(reload_addr, 8'h5a)
		wr(IDX_MSK, 8'h3c);
		wr(IDX_CON3, 8'hc3);
		settle();
		rd(IDX_MSK, 8'h3c);
		rd(IDX_CON3, 8'hc3);
		`CHK(addr_mask, 8'h3c)
		`CHK(ctrl_three, 8'hc3)
		print_verdict();
	end
endmodule
